// file: verilog/csp_pkg.sv
// Constants, register map and field layout of the clocked serial shift port.
// Assumes a single 250 MHz system clock and a plain strobe register port.
`default_nettype none
package csp_pkg;

	// ****************************************************************
	// Register map (byte addresses on the register port)
	// ****************************************************************
	localparam logic [7:0] CSP_ADDR_CONTROL   = 8'hE1;
	localparam logic [7:0] CSP_ADDR_DATA      = 8'hE2;
	localparam logic [7:0] CSP_ADDR_PRESCALER = 8'hE3;
	localparam logic [7:0] CSP_ADDR_PENDING   = 8'hE4;
	localparam logic [7:0] CSP_ADDR_MASK      = 8'hE5;

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int CSP_CTL_DIR_LSB   = 0;
	localparam int CSP_CTL_MODE_TX   = 1;
	localparam int CSP_CTL_SHIFT_EN  = 2;
	localparam int CSP_CTL_START     = 3;
	localparam int CSP_CTL_EDGE_RISE = 4;
	localparam int CSP_CTL_IRQ_EN    = 5;
	localparam int CSP_CTL_CLK_EXT   = 6;

	// Pending register: serial done flag position
	localparam int CSP_PND_DONE = 2;

	// ****************************************************************
	// Reset values and counts
	// ****************************************************************
	localparam logic [7:0] CSP_CONTROL_RST   = 8'h00;
	localparam logic [7:0] CSP_PRESCALER_RST = 8'h00;
	localparam logic [7:0] CSP_DATA_RST      = 8'h00;
	localparam logic [7:0] CSP_MASK_RST      = 8'h00;
	localparam logic [1:0] CSP_FXX_DIV_LAST  = 2'h3;
	localparam logic [2:0] CSP_BIT_LAST      = 3'h7;

	// Shifter state
	typedef enum logic [1:0] {
		CSP_IDLE = 2'b00,
		CSP_LOW  = 2'b01,
		CSP_HIGH = 2'b10
	} csp_state_t;

endpackage
`default_nettype wire

// file: verilog/csp_tick_if.sv
// Interface carrying the internal shift clock ticks from the divider.
// Assumes both ends run on mclk.
`timescale 1ns/100ps
`default_nettype none
interface csp_tick_if;
	logic       run;
	logic [7:0] divisor;
	logic       tick;
	modport src (input run, input divisor, output tick);
	modport dst (output run, output divisor, input tick);
endinterface
`default_nettype wire

// file: verilog/csp_prescaler.sv
// Internal shift clock divider: fxx/4 then /(prescaler+1), half-period ticks.
// Assumes run is low whenever no internal transfer is active.
`timescale 1ns/100ps
`default_nettype none
module csp_prescaler (
	input  wire logic mclk,
	input  wire logic sys_rst,
	csp_tick_if.src   tk
);
	logic [1:0] quarter_reg;
	logic [7:0] count_reg;
	logic       tick_reg;

	// ****************************************************************
	// Divider chain
	// ****************************************************************
	// Tick marks one half of the shift clock period (two per bit)
	always_ff @(posedge mclk) begin
		if (sys_rst || !tk.run) begin
			quarter_reg <= 2'h0;
			count_reg   <= 8'h00;
			tick_reg    <= 1'b0;
		end else begin
			tick_reg <= 1'b0;
			quarter_reg <= quarter_reg + 2'h1;
			// Fixed divide by four ahead of the programmable stage
			if (quarter_reg == csp_pkg::CSP_FXX_DIV_LAST) begin
				if (count_reg == tk.divisor) begin
					count_reg <= 8'h00;
					tick_reg  <= 1'b1;
				end else begin
					count_reg <= count_reg + 8'h01;
				end
			end
		end
	end

	assign tk.tick = tick_reg;
endmodule
`default_nettype wire

// file: verilog/csp_top.sv
// Clocked serial shift port: control, prescaler, data buffer, pending flag.
// Assumes pins come from outside mclk and are synchronised here.
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Shifting happens only while the shifter enable bit is one.
// - Writing a byte and setting the start bit begins shifting that byte.
// - The start bit clears the bit counter and launches a new transfer.
// - A finished transfer sets the pending flag and requests an interrupt.
// - The interrupt is delivered only when the interrupt enable bit is one.
// - Reset clears the control register to zero.
// - Zero control means internal clock, receive only, MSB first, all off.
// - Internal rate is the system clock over eight over prescaler plus one.
// - The edge bit picks falling (0) or rising (1) edges for outgoing data.
// - Each transfer moves exactly eight bits counted by a 3-bit counter.
// - The clock source bit picks internal drive or external clock input.
// - The mode bit picks transmit and receive or receive only.
// - The direction bit picks MSB first or LSB first both ways.
// - The prescaler register holds an 8-bit divider value.
module csp_top (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire logic       sdi,
	output logic            sdo,
	output logic            sdo_oe,
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe,
	output logic            irq
);
	csp_tick_if tk ();

	logic [7:0]          control_reg;
	logic [7:0]          prescaler_reg;
	logic [7:0]          data_reg;
	logic [7:0]          mask_reg;
	logic                pending_reg;
	logic [7:0]          rdata_reg;
	logic [2:0]          bitcnt_reg;
	csp_pkg::csp_state_t state_reg;
	logic                sck_level_reg;
	logic                sdo_reg;
	logic                sdi_s1_reg;
	logic                sdi_s2_reg;
	logic                sck_s1_reg;
	logic                sck_s2_reg;
	logic                sck_s3_reg;
	logic                done_pulse;
	logic                ext_sel;
	logic                lsb_first;
	logic                rise_tx;
	logic                wr_ctl;
	logic                start_req;
	logic                edge_rise;
	logic                edge_fall;
	logic                tx_edge;
	logic                rx_edge;

	// ****************************************************************
	// Control field decode
	// ****************************************************************
	assign ext_sel   = control_reg[csp_pkg::CSP_CTL_CLK_EXT];
	assign lsb_first = control_reg[csp_pkg::CSP_CTL_DIR_LSB];
	assign rise_tx   = control_reg[csp_pkg::CSP_CTL_EDGE_RISE];
	assign wr_ctl    = reg_wr && (reg_addr == csp_pkg::CSP_ADDR_CONTROL);
	// Start needs the shifter enabled in the same write
	assign start_req = wr_ctl && reg_wdata[csp_pkg::CSP_CTL_START]
		&& reg_wdata[csp_pkg::CSP_CTL_SHIFT_EN];

	// Next bit out of the buffer in the selected order
	function automatic logic out_bit(input logic [7:0] d, input logic lsb);
		out_bit = lsb ? d[0] : d[7];
	endfunction

	// Buffer after shifting one sampled bit in
	function automatic logic [7:0] shift_in(input logic [7:0] d, input logic lsb,
		input logic b);
		shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
	endfunction

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Two flops on each pin; a third sck flop only for edge detection
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sdi_s1_reg <= 1'b0;
			sdi_s2_reg <= 1'b0;
			sck_s1_reg <= 1'b1;
			sck_s2_reg <= 1'b1;
			sck_s3_reg <= 1'b1;
		end else begin
			sdi_s1_reg <= sdi;
			sdi_s2_reg <= sdi_s1_reg;
			sck_s1_reg <= sck_in;
			sck_s2_reg <= sck_s1_reg;
			sck_s3_reg <= sck_s2_reg;
		end
	end

	// ****************************************************************
	// Shift clock edges
	// ****************************************************************
	// Internal: each tick toggles the idle-high clock
	assign edge_fall = (state_reg != csp_pkg::CSP_IDLE) && (ext_sel
		? (sck_s3_reg && !sck_s2_reg)
		: (tk.tick && sck_level_reg));
	assign edge_rise = (state_reg != csp_pkg::CSP_IDLE) && (ext_sel
		? (!sck_s3_reg && sck_s2_reg)
		: (tk.tick && !sck_level_reg));
	assign tx_edge = rise_tx ? edge_rise : edge_fall;
	assign rx_edge = rise_tx ? edge_fall : edge_rise;

	assign tk.run     = (state_reg != csp_pkg::CSP_IDLE) && !ext_sel;
	assign tk.divisor = prescaler_reg;

	csp_prescaler u_div (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.tk      (tk)
	);

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// Control; start bit is self clearing
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			control_reg <= csp_pkg::CSP_CONTROL_RST;
		end else if (wr_ctl) begin
			control_reg <= reg_wdata & ~(8'h01 << csp_pkg::CSP_CTL_START);
		end
	end

	// Prescaler divider value
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			prescaler_reg <= csp_pkg::CSP_PRESCALER_RST;
		end else if (reg_wr && reg_addr == csp_pkg::CSP_ADDR_PRESCALER) begin
			prescaler_reg <= reg_wdata;
		end
	end

	// Interrupt mask, same layout as pending
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mask_reg <= csp_pkg::CSP_MASK_RST;
		end else if (reg_wr && reg_addr == csp_pkg::CSP_ADDR_MASK) begin
			mask_reg <= reg_wdata;
		end
	end

	// ****************************************************************
	// Shift engine
	// ****************************************************************
	// Idle high clock; low half then high half per bit
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg     <= csp_pkg::CSP_IDLE;
			bitcnt_reg    <= 3'h0;
			sck_level_reg <= 1'b1;
			done_pulse    <= 1'b0;
		end else begin
			done_pulse <= 1'b0;
			if (start_req) begin
				state_reg     <= csp_pkg::CSP_LOW;
				bitcnt_reg    <= 3'h0;
				sck_level_reg <= 1'b1;
			end else if (!control_reg[csp_pkg::CSP_CTL_SHIFT_EN]) begin
				state_reg     <= csp_pkg::CSP_IDLE;
				sck_level_reg <= 1'b1;
			end else begin
				case (state_reg)
				csp_pkg::CSP_LOW: begin
					if (edge_fall) begin
						sck_level_reg <= 1'b0;
						state_reg     <= csp_pkg::CSP_HIGH;
					end
				end
				csp_pkg::CSP_HIGH: begin
					if (edge_rise) begin
						sck_level_reg <= 1'b1;
						if (bitcnt_reg == csp_pkg::CSP_BIT_LAST) begin
							state_reg  <= csp_pkg::CSP_IDLE;
							done_pulse <= 1'b1;
						end else begin
							state_reg <= csp_pkg::CSP_LOW;
						end
						bitcnt_reg <= bitcnt_reg + 3'h1;
					end
				end
				default: begin
					state_reg <= csp_pkg::CSP_IDLE;
				end
				endcase
			end
		end
	end

	// Data buffer: software write, receive shift and transmit bit
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			data_reg <= csp_pkg::CSP_DATA_RST;
			sdo_reg  <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == csp_pkg::CSP_ADDR_DATA) begin
				data_reg <= reg_wdata;
			end else if (rx_edge) begin
				data_reg <= shift_in(data_reg, lsb_first, sdi_s2_reg);
			end
			if (tx_edge) begin
				sdo_reg <= out_bit(data_reg, lsb_first);
			end
		end
	end

	// ****************************************************************
	// Pending flag and interrupt
	// ****************************************************************
	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pending_reg <= 1'b0;
		end else if (done_pulse) begin
			pending_reg <= 1'b1;
		end else if (reg_wr && reg_addr == csp_pkg::CSP_ADDR_PENDING
			&& reg_wdata[csp_pkg::CSP_PND_DONE]) begin
			pending_reg <= 1'b0;
		end
	end

	// Level request gated by enable bit and mask
	assign irq = pending_reg && control_reg[csp_pkg::CSP_CTL_IRQ_EN]
		&& mask_reg[csp_pkg::CSP_PND_DONE];

	// ****************************************************************
	// Register reads
	// ****************************************************************
	// Read data stands in the cycle after the strobe only
	always_ff @(posedge mclk) begin
		if (sys_rst || !reg_rd) begin
			rdata_reg <= 8'h00;
		end else if (reg_addr == csp_pkg::CSP_ADDR_CONTROL) begin
			rdata_reg <= control_reg;
		end else if (reg_addr == csp_pkg::CSP_ADDR_DATA) begin
			rdata_reg <= data_reg;
		end else if (reg_addr == csp_pkg::CSP_ADDR_PRESCALER) begin
			rdata_reg <= prescaler_reg;
		end else if (reg_addr == csp_pkg::CSP_ADDR_PENDING) begin
			rdata_reg <= {5'h00, pending_reg, 2'h0};
		end else if (reg_addr == csp_pkg::CSP_ADDR_MASK) begin
			rdata_reg <= mask_reg;
		end else begin
			rdata_reg <= 8'h00;
		end
	end
	assign reg_rdata = rdata_reg;

	// ****************************************************************
	// Pins
	// ****************************************************************
	assign sck_out = sck_level_reg;
	assign sck_oe  = !ext_sel;
	assign sdo     = sdo_reg;
	assign sdo_oe  = control_reg[csp_pkg::CSP_CTL_MODE_TX];
endmodule
`default_nettype wire

// file: verif/csp_serial_dev.sv
// Far side serial device: shifts MSB first, makes the clock when external.
// Assumes sck is the resolved clock pin level and mclk the system clock.
`timescale 1ns/100ps
`default_nettype none
// ****************
// Device model
// ****************
module csp_serial_dev (
	input  wire logic       mclk,
	input  wire logic       sck,
	input  wire logic       sdo,
	input  wire logic       rise_tx,
	input  wire logic       load,
	input  wire logic       ext_go,
	input  wire logic [7:0] tx_byte,
	output logic            sdi,
	output logic            ext_sck,
	output logic [7:0]      rx_byte
);
	logic [7:0] sh;
	initial begin
		sdi = 1'b0;
		ext_sck = 1'b1;
		sh = 8'h00;
		rx_byte = 8'h00;
	end
	// Load a byte; the idle line flips so a stale level is never read
	always @(posedge mclk) begin
		if (load) begin
			sh <= tx_byte;
			sdi <= ~sdi;
		end
	end
	// Drive on the transmit edge, sample on the other one
	always @(sck) begin
		if (sck === rise_tx) begin
			sdi <= sh[7];
			sh <= {sh[6:0], 1'b0};
		end else begin
			rx_byte <= {rx_byte[6:0], sdo};
		end
	end
	// Eight clocks per byte, idle high between frames
	always @(posedge mclk) begin
		if (ext_go) begin
			repeat (8) begin
				repeat (8) @(posedge mclk);
				ext_sck <= 1'b0;
				repeat (8) @(posedge mclk);
				ext_sck <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: verif/csp_top_checker.sv
// Assertions on the serial shift port, bound to its top module.
// Assumes only top ports are seen; control fields are shadowed here.
`timescale 1ns/100ps
`default_nettype none
module csp_top_checker (
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       sdi,
	input wire logic       sdo,
	input wire logic       sdo_oe,
	input wire logic       sck_in,
	input wire logic       sck_out,
	input wire logic       sck_oe,
	input wire logic       irq
);
	// ****************
	// Shadow state
	// ****************
	logic [7:0]  ctl_reg;
	logic        msk_reg;
	logic [7:0]  ps_reg;
	logic [3:0]  rise_reg;
	logic [10:0] half_reg;
	logic        sck_reg;
	logic        ctl_wr;
	assign ctl_wr = reg_wr && reg_addr == csp_pkg::CSP_ADDR_CONTROL;
	// Control, mask and prescaler as software wrote them
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctl_reg <= 8'h00;
			msk_reg <= 1'b0;
			ps_reg <= 8'h00;
		end else begin
			if (ctl_wr) begin
				ctl_reg <= reg_wdata;
			end
			if (reg_wr && reg_addr == csp_pkg::CSP_ADDR_PRESCALER) begin
				ps_reg <= reg_wdata;
			end
			if (reg_wr && reg_addr == 8'hE5) begin
				msk_reg <= reg_wdata[2];
			end
		end
	end
	// Internal rising edges since the last start, saturating
	always_ff @(posedge mclk) begin
		if (sys_rst || (ctl_wr && reg_wdata[3])) begin
			rise_reg <= 4'h0;
		end else if ($rose(sck_out) && sck_oe && ctl_reg[2] && rise_reg != 4'hF) begin
			rise_reg <= rise_reg + 4'h1;
		end
	end
	// Cycles since the clock pin last changed
	always_ff @(posedge mclk) begin
		sck_reg <= sck_out;
		half_reg <= (sys_rst || sck_out != sck_reg) ? 11'h001 : half_reg + 11'h001;
	end
	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	sequence s_last_rise;
		$rose(sck_out) && sck_oe && ctl_reg[2] && rise_reg == 4'h7;
	endsequence
	a_idle_clock: assert property (
		!ctl_reg[2] && !$past(ctl_reg[2]) && !$past(ctl_reg[2], 2) |-> sck_out)
		else $error("clock moved while off");
	a_start_go: assert property (
		ctl_wr && reg_wdata[3:2] == 2'b11 && !reg_wdata[6] |-> ##[1:1000] $fell(sck_out))
		else $error("start gave no clock");
	a_eight_bits: assert property (rise_reg <= 4'h8)
		else $error("more than eight bits");
	a_done_irq: assert property (s_last_rise ##0 (ctl_reg[5] && msk_reg) |-> ##[0:3] irq)
		else $error("no interrupt after byte");
	a_irq_gate: assert property (
		irq |-> (ctl_reg[5] || $past(ctl_reg[5])) && (msk_reg || $past(msk_reg)))
		else $error("interrupt while disabled");
	a_half_period: assert property (
		$rose(sck_out) && sck_oe && ctl_reg[2] |-> half_reg == ({3'h0, ps_reg} + 11'h001) << 2)
		else $error("wrong half period");
	a_tx_edge: assert property (
		sck_oe && ctl_reg[2] && ctl_reg[1] && !ctl_reg[4] && rise_reg < 4'h8 && $changed(sdo)
		&& !$past(reg_wr) && !$past(reg_wr, 2) |-> $fell(sck_out))
		else $error("data moved off the falling edge");
	a_clk_source: assert property (sck_oe == !ctl_reg[6])
		else $error("clock drive wrong");
	a_out_mode: assert property (sdo_oe == ctl_reg[1])
		else $error("data drive wrong");
endmodule
bind csp_top csp_top_checker u_chk (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .sdi, .sdo, .sdo_oe, .sck_in, .sck_out, .sck_oe, .irq);
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the serial shift port with a far side device.
// Assumes the checker is bound to the design top by its own file.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("FAIL %s expected %h seen %h", nm, e, g); \
	end \
end
module testbench;
	localparam logic [7:0] A_C = csp_pkg::CSP_ADDR_CONTROL;
	localparam logic [7:0] A_D = csp_pkg::CSP_ADDR_DATA;
	localparam logic [7:0] A_P = csp_pkg::CSP_ADDR_PRESCALER;
	localparam logic [7:0] A_N = csp_pkg::CSP_ADDR_PENDING;
	logic       mclk, sys_rst, reg_wr, reg_rd, sdo, sdo_oe, sck_out, sck_oe, irq;
	logic       sdi, ext_sck, load, ext_go, rise_tx;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_byte, rx_byte;
	wire        sck;
	wire        sdo_pin;
	int         error_cnt, n_compared;
	// Clock pin level: the port drives it unless the clock is external
	assign sck = sck_oe ? sck_out : ext_sck;
	// Released data line floats to its pull-up level
	assign sdo_pin = sdo_oe ? sdo : 1'b1;
	always #2 mclk = ~mclk;
	csp_top DUT (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.sdi, .sdo, .sdo_oe, .sck_in(sck), .sck_out, .sck_oe, .irq);
	csp_serial_dev u_dev (.mclk, .sck, .sdo(sdo_pin), .rise_tx, .load, .ext_go, .tx_byte, .sdi,
		.ext_sck, .rx_byte);
	// ****************
	// Register port tasks
	// ****************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 `CHK(nm, e, reg_rdata)
	endtask
	function automatic logic [7:0] rev(input logic [7:0] b);
		for (int k = 0; k < 8; k++) rev[k] = b[7-k];
	endfunction
	task automatic results();
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// One byte each way with a control value, prescaler and both data bytes
	task automatic xfer(input logic [7:0] c, input logic [7:0] p, input logic [7:0] d,
		input logic [7:0] t);
		int i;
		tx_byte <= t;
		rise_tx <= c[4];
		wr(A_P, p);
		wr(A_D, d);
		wr(A_N, 8'h04);
		load <= 1'b1;
		ext_go <= c[6];
		wr(A_C, c | 8'h0C);
		load <= 1'b0;
		ext_go <= 1'b0;
		for (i = 0; i < 9000; i++) begin
			@(posedge mclk);
			reg_rd <= 1'b1;
			reg_addr <= A_N;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1 if (reg_rdata[2] === 1'b1) break;
		end
		if (i == 9000) begin
			error_cnt++;
			results();
		end
		`CHK("pending", 8'h04, reg_rdata)
		`CHK("irq", c[5], irq)
		rc(A_C, c | 8'h04, "control");
		if (!c[4]) begin
			rc(A_D, c[0] ? rev(t) : t, "data in");
			if (c[1]) `CHK("data out", c[0] ? rev(d) : d, rx_byte)
			else `CHK("released out", 8'hFF, rx_byte)
		end
		wr(A_N, 8'h04);
		@(posedge mclk);
		#1 `CHK("irq cleared", 1'b0, irq)
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		{mclk, reg_wr, reg_rd, load, ext_go, rise_tx} = 6'h00;
		{reg_addr, reg_wdata, tx_byte} = 24'h000000;
		sys_rst = 1'b1;
		error_cnt = 0;
		n_compared = 0;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		rc(A_C, 8'h00, "control reset");
		rc(A_N, 8'h00, "pending reset");
		`CHK("clock drive", 1'b1, sck_oe)
		`CHK("data drive", 1'b0, sdo_oe)
		wr(8'h10, 8'hFF);
		rc(8'h10, 8'h00, "unmapped");
		wr(A_P, 8'h5A);
		rc(A_P, 8'h5A, "prescaler");
		wr(8'hE5, 8'h04);
		xfer(8'h22, 8'h01, 8'h3C, 8'hA5);
		xfer(8'h23, 8'h00, 8'h1E, 8'hB4);
		xfer(8'h02, 8'hC8, 8'hC3, 8'h5A);
		xfer(8'h20, 8'h02, 8'h99, 8'h66);
		xfer(8'h32, 8'h01, 8'h0F, 8'hF0);
		xfer(8'h62, 8'h00, 8'h6D, 8'h2B);
		wr(A_C, 8'h0E);
		repeat (20) @(posedge mclk);
		wr(A_C, 8'h02);
		repeat (300) @(posedge mclk);
		rc(A_N, 8'h00, "aborted");
		`CHK("clock idle", 1'b1, sck_out)
		results();
	end
endmodule
`default_nettype wire
